//--- logic/iefl_irq_enable_flag.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - Core control bit 4 enables the external pin interrupt.
// - Core control bit 0 sets when any upper port B pin changes.
// - Peripheral requests need the group enable bit set.
// - Peripheral enable register sits at 0x8c, one bit per source.
// - Unimplemented bits read as zero.
// - Peripheral enable bit 3 gates the synchronous serial port interrupt.
// - Peripheral enable bit 2 gates the capture/compare unit one interrupt.
// - Peripheral enable bit 1 gates the timer two period match interrupt.
// - Peripheral enable bit 0 gates the timer one overflow interrupt.
// - With serial transceiver, bit 5 gates the serial receive interrupt.
// - With serial transceiver, bit 4 gates the serial transmit interrupt.
// - Implemented peripheral enable bits are read/write and reset to zero.
// - Flags set on their condition regardless of any enable.
// - Global enable passes unmasked interrupts; cleared, it blocks them all.
module iefl_irq_enable_flag #(
    parameter bit HAS_SERIAL = 1'b1,
    parameter bit HAS_GROUP_EN = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pins
    input wire logic ext_irq_pin_i,
    input wire logic [3:0] upper_port_b_pins_i,
    input wire logic ext_edge_rising_i,
    // Peripheral events, same clock, one-cycle pulses
    input wire logic timer_zero_ovf_i,
    input wire logic [5:0] periph_event_i,
    // CPU
    output logic cpu_irq_o
);
    localparam logic [7:0] PE_MASK = HAS_SERIAL ? iefl_pkg::PE_MASK_SERIAL : iefl_pkg::PE_MASK_BASIC;

    iefl_sync_if sync ();

    iefl_pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ext_irq_pin_i(ext_irq_pin_i),
        .upper_port_b_pins_i(upper_port_b_pins_i),
        .sync(sync)
    );

    logic [7:0] core_irq_control_q;
    logic [7:0] peripheral_irq_enable_q;
    logic [5:0] periph_flag_q;
    logic ext_prev_q;
    logic [3:0] port_prev_q;
    logic prev_valid_q;

    // Bus address phase capture
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic addr_ok;
    logic rd_now;

    assign addr_ok = hsel_i && hready_i && htrans_i[1];
    assign rd_now = addr_ok && !hwrite_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite_i;
            if (addr_ok) begin
                wr_addr_q <= haddr_i[7:0];
            end
        end
    end

    logic wr_core;
    logic wr_pe;
    logic wr_pf;
    assign wr_core = wr_pend_q && (wr_addr_q == iefl_pkg::CORE_CTRL_ADDR);
    assign wr_pe = wr_pend_q && (wr_addr_q == iefl_pkg::PERIPH_EN_ADDR);
    assign wr_pf = wr_pend_q && (wr_addr_q == iefl_pkg::PERIPH_FLAG_ADDR);

    // Event detection on synchronised pins
    logic ext_edge;
    logic port_change;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_prev_q <= 1'b0;
            port_prev_q <= 4'h0;
            prev_valid_q <= 1'b0;
        end else begin
            ext_prev_q <= sync.ext_pin;
            port_prev_q <= sync.port_pins;
            prev_valid_q <= 1'b1;
        end
    end

    assign ext_edge = prev_valid_q && (ext_edge_rising_i ? (sync.ext_pin && !ext_prev_q)
                                                         : (!sync.ext_pin && ext_prev_q));
    assign port_change = prev_valid_q && (sync.port_pins != port_prev_q);

    // Core control register: enables from software, flags set by hardware win over clear
    logic [7:0] core_wmask;
    assign core_wmask = HAS_GROUP_EN ? 8'hff : 8'hbf;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            core_irq_control_q <= iefl_pkg::CORE_CTRL_RST;
        end else begin
            logic [7:0] nxt;
            nxt = core_irq_control_q;
            if (wr_core) begin
                nxt = hwdata_i[7:0] & core_wmask;
            end
            if (timer_zero_ovf_i) begin
                nxt[iefl_pkg::CC_TIMER_ZERO_FLAG] = 1'b1;
            end
            if (ext_edge) begin
                nxt[iefl_pkg::CC_EXT_FLAG] = 1'b1;
            end
            if (port_change) begin
                nxt[iefl_pkg::CC_PORT_FLAG] = 1'b1;
            end
            core_irq_control_q <= nxt;
        end
    end

    // Peripheral enable register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            peripheral_irq_enable_q <= iefl_pkg::PERIPH_EN_RST;
        end else if (wr_pe) begin
            peripheral_irq_enable_q <= hwdata_i[7:0] & PE_MASK;
        end
    end

    // Peripheral flags latched from events; software writes zero to clear
    logic [5:0] pf_impl;
    assign pf_impl = PE_MASK[5:0];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            periph_flag_q <= 6'h00;
        end else begin
            logic [5:0] nxt;
            nxt = periph_flag_q;
            if (wr_pf) begin
                nxt = hwdata_i[5:0];
            end
            nxt = (nxt | periph_event_i) & pf_impl;
            periph_flag_q <= nxt;
        end
    end

    // Request combination
    logic core_req;
    logic periph_req;
    logic [5:0] pe_en;
    assign pe_en[iefl_pkg::PE_SERIAL_RX] = peripheral_irq_enable_q[iefl_pkg::PE_SERIAL_RX];
    assign pe_en[iefl_pkg::PE_SERIAL_TX] = peripheral_irq_enable_q[iefl_pkg::PE_SERIAL_TX];
    assign pe_en[iefl_pkg::PE_SYNC_SERIAL] = peripheral_irq_enable_q[iefl_pkg::PE_SYNC_SERIAL];
    assign pe_en[iefl_pkg::PE_CAPCMP_ONE] = peripheral_irq_enable_q[iefl_pkg::PE_CAPCMP_ONE];
    assign pe_en[iefl_pkg::PE_TIMER_TWO] = peripheral_irq_enable_q[iefl_pkg::PE_TIMER_TWO];
    assign pe_en[iefl_pkg::PE_TIMER_ONE] = peripheral_irq_enable_q[iefl_pkg::PE_TIMER_ONE];

    assign core_req = (core_irq_control_q[iefl_pkg::CC_TIMER_ZERO_EN] && core_irq_control_q[iefl_pkg::CC_TIMER_ZERO_FLAG])
        || (core_irq_control_q[iefl_pkg::CC_EXT_EN] && core_irq_control_q[iefl_pkg::CC_EXT_FLAG])
        || (core_irq_control_q[iefl_pkg::CC_PORT_EN] && core_irq_control_q[iefl_pkg::CC_PORT_FLAG]);
    assign periph_req = core_irq_control_q[iefl_pkg::CC_GROUP_EN] && |(pe_en & periph_flag_q);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_irq_o <= 1'b0;
        end else begin
            cpu_irq_o <= core_irq_control_q[iefl_pkg::CC_GLOBAL_EN] && (core_req || periph_req);
        end
    end

    // Read data, registered in the address phase
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_now) begin
            unique case (haddr_i[7:0])
                iefl_pkg::CORE_CTRL_ADDR: rdata_q <= {24'h00_0000, core_irq_control_q};
                iefl_pkg::PERIPH_EN_ADDR: rdata_q <= {24'h00_0000, peripheral_irq_enable_q};
                iefl_pkg::PERIPH_FLAG_ADDR: rdata_q <= {26'h000_0000, periph_flag_q};
                iefl_pkg::EVENT_SRC_ADDR: rdata_q <= {27'h000_0000, sync.ext_pin, sync.port_pins};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
endmodule

//--- logic/iefl_pkg.sv
package iefl_pkg;
    // Byte addresses on the register bus
    localparam logic [7:0] CORE_CTRL_ADDR = 8'h0b;
    localparam logic [7:0] PERIPH_EN_ADDR = 8'h8c;
    localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h0c;
    localparam logic [7:0] EVENT_SRC_ADDR = 8'h10;
    // Core control field positions
    localparam int CC_GLOBAL_EN = 7;
    localparam int CC_GROUP_EN = 6;
    localparam int CC_TIMER_ZERO_EN = 5;
    localparam int CC_EXT_EN = 4;
    localparam int CC_PORT_EN = 3;
    localparam int CC_TIMER_ZERO_FLAG = 2;
    localparam int CC_EXT_FLAG = 1;
    localparam int CC_PORT_FLAG = 0;
    // Peripheral enable field positions
    localparam int PE_SERIAL_RX = 5;
    localparam int PE_SERIAL_TX = 4;
    localparam int PE_SYNC_SERIAL = 3;
    localparam int PE_CAPCMP_ONE = 2;
    localparam int PE_TIMER_TWO = 1;
    localparam int PE_TIMER_ONE = 0;
    // Reset values
    localparam logic [7:0] CORE_CTRL_RST = 8'h00;
    localparam logic [7:0] PERIPH_EN_RST = 8'h00;
    // Writable masks of the peripheral enable register per layout
    localparam logic [7:0] PE_MASK_BASIC = 8'h0f;
    localparam logic [7:0] PE_MASK_SERIAL = 8'h3f;
endpackage

//--- logic/iefl_sync_if.sv
`timescale 1ns/1ps
interface iefl_sync_if;
    logic ext_pin;
    logic [3:0] port_pins;
    modport src (output ext_pin, output port_pins);
    modport dst (input ext_pin, input port_pins);
endinterface

//--- logic/iefl_pin_sync.sv
`timescale 1ns/1ps
module iefl_pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Raw pins
    input wire logic ext_irq_pin_i,
    input wire logic [3:0] upper_port_b_pins_i,
    // Synchronised pins
    iefl_sync_if.src sync
);
    logic [4:0] stage1_q;
    logic [4:0] stage2_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage1_q <= 5'h00;
            stage2_q <= 5'h00;
        end else begin
            stage1_q <= {ext_irq_pin_i, upper_port_b_pins_i};
            stage2_q <= stage1_q;
        end
    end

    assign sync.ext_pin = stage2_q[4];
    assign sync.port_pins = stage2_q[3:0];
endmodule

//--- dv/iefl_irq_enable_flag_chk.sv
`timescale 1ns/1ps
module iefl_irq_enable_flag_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Events and request
    input wire logic ext_irq_pin_i,
    input wire logic [3:0] upper_port_b_pins_i,
    input wire logic ext_edge_rising_i,
    input wire logic timer_zero_ovf_i,
    input wire logic [5:0] periph_event_i,
    input wire logic cpu_irq_o
);
    logic rd_q, wr_q;
    logic [7:0] ad_q, cc_q, pe_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Data phase tracking
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
        end else if (hready_i) begin
            rd_q <= hsel_i && htrans_i[1] && !hwrite_i;
            wr_q <= hsel_i && htrans_i[1] && hwrite_i;
            ad_q <= haddr_i[7:0];
        end
    end
    // Shadow of the enable registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cc_q <= 8'h00;
            pe_q <= 8'h00;
        end else if (wr_q && ad_q == iefl_pkg::CORE_CTRL_ADDR) begin
            cc_q <= hwdata_i[7:0];
        end else if (wr_q && ad_q == iefl_pkg::PERIPH_EN_ADDR) begin
            pe_q <= hwdata_i[7:0] & iefl_pkg::PE_MASK_SERIAL;
        end
    end
    sequence s_fire;
        ##2 cpu_irq_o;
    endsequence
    property p_okay;
        hreadyout_o && !hresp_o;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not ready");
    property p_hi;
        rd_q |-> hrdata_o[31:8] == 24'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_pe;
        rd_q && ad_q == iefl_pkg::PERIPH_EN_ADDR |-> hrdata_o[7:0] == pe_q;
    endproperty
    a_pe: assert property (p_pe) else $error("enable readback");
    property p_gie;
        !cc_q[7] |=> !cpu_irq_o;
    endproperty
    a_gie: assert property (p_gie) else $error("irq while global off");
    property p_t0;
        timer_zero_ovf_i && cc_q[7] && cc_q[5] && !wr_q |-> s_fire;
    endproperty
    a_t0: assert property (p_t0) else $error("timer irq missing");
    property p_pev;
        (periph_event_i & pe_q[5:0]) != 6'h00 && cc_q[7] && cc_q[6] && !wr_q |-> s_fire;
    endproperty
    a_pev: assert property (p_pev) else $error("periph irq missing");
    property p_ext;
        $rose(ext_irq_pin_i) && ext_edge_rising_i && cc_q[7] && cc_q[4] |-> ##[2:6] cpu_irq_o;
    endproperty
    a_ext: assert property (p_ext) else $error("pin irq missing");
    property p_port;
        $changed(upper_port_b_pins_i) && cc_q[7] && cc_q[3] |-> ##[2:6] cpu_irq_o;
    endproperty
    a_port: assert property (p_port) else $error("port irq missing");
endmodule
bind iefl_irq_enable_flag iefl_irq_enable_flag_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_irq_pin_i(ext_irq_pin_i),
    .upper_port_b_pins_i(upper_port_b_pins_i), .ext_edge_rising_i(ext_edge_rising_i),
    .timer_zero_ovf_i(timer_zero_ovf_i), .periph_event_i(periph_event_i), .cpu_irq_o(cpu_irq_o));

//--- dv/iefl_evt_src.sv
`timescale 1ns/1ps
module iefl_evt_src (
    input wire logic clk_i,
    output logic timer_zero_ovf_o = 1'b0,
    output logic [5:0] periph_event_o = 6'h00,
    output logic ext_irq_pin_o = 1'b0,
    output logic [3:0] port_pins_o = 4'h0
);
    // One-cycle event; index 6 is the timer zero overflow
    task automatic pulse(input int n);
        @(posedge clk_i);
        if (n == 6) timer_zero_ovf_o <= 1'b1;
        else periph_event_o[n] <= 1'b1;
        @(posedge clk_i);
        timer_zero_ovf_o <= 1'b0;
        periph_event_o <= 6'h00;
    endtask
    task automatic pins(input logic e, input logic [3:0] p);
        @(posedge clk_i);
        ext_irq_pin_o <= e;
        port_pins_o <= p;
    endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] CC = iefl_pkg::CORE_CTRL_ADDR;
    localparam logic [7:0] PE = iefl_pkg::PERIPH_EN_ADDR;
    localparam logic [7:0] PF = iefl_pkg::PERIPH_FLAG_ADDR;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'b00;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, rdat;
    logic hreadyout_o, hresp_o, cpu_irq_o, t0_ovf, ext_pin;
    logic edge_rise = 1'b1;
    logic [5:0] pev;
    logic [3:0] pins;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 clk_i = ~clk_i;
    iefl_evt_src src_u (.clk_i(clk_i), .timer_zero_ovf_o(t0_ovf), .periph_event_o(pev), .ext_irq_pin_o(ext_pin),
        .port_pins_o(pins));
    iefl_irq_enable_flag dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_irq_pin_i(ext_pin),
        .upper_port_b_pins_i(pins), .ext_edge_rising_i(edge_rise), .timer_zero_ovf_i(t0_ovf), .periph_event_i(pev),
        .cpu_irq_o(cpu_irq_o));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        haddr_i <= {24'h0, a};
        htrans_i <= 2'b10;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= {24'h0, d};
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rdat = hrdata_o;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), exp, rdat);
    endtask
    task automatic irq(input int n, input logic e);
        repeat (n) @(posedge clk_i);
        // Look after the edge has settled the registered request
        #1;
        chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq_o});
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(PE, 32'h0);
        rd(8'h40, 32'h0);
        xfer(1'b1, PE, 8'h3f);
        rd(PE, 32'h3f);
        for (int n = 0; n < 6; n++) begin
            xfer(1'b1, CC, 8'hc0);
            xfer(1'b1, PE, 8'h00);
            src_u.pulse(n);
            irq(3, 1'b0);
            rd(PF, 32'h1 << n);
            xfer(1'b1, PE, 8'h1 << n);
            irq(3, 1'b1);
            xfer(1'b1, PF, 8'h00);
            xfer(1'b1, CC, 8'h80);
            src_u.pulse(n);
            irq(3, 1'b0);
            xfer(1'b1, PF, 8'h00);
        end
        xfer(1'b1, CC, 8'ha0);
        src_u.pulse(6);
        irq(3, 1'b1);
        xfer(1'b1, CC, 8'h24);
        irq(2, 1'b0);
        rd(CC, 32'h24);
        xfer(1'b1, CC, 8'h90);
        src_u.pins(1'b1, 4'h0);
        irq(7, 1'b1);
        rd(CC, 32'h92);
        xfer(1'b1, CC, 8'h82);
        irq(2, 1'b0);
        xfer(1'b1, CC, 8'h88);
        src_u.pins(1'b1, 4'ha);
        irq(7, 1'b1);
        rd(CC, 32'h89);
        // Falling edge selection on the external pin
        edge_rise <= 1'b0;
        xfer(1'b1, CC, 8'h90);
        src_u.pins(1'b0, 4'ha);
        irq(7, 1'b1);
        rd(CC, 32'h92);
        finish_test();
    end
endmodule
